// >>> common/clkgen_cfg_defines.svh
`ifndef CLKGEN_CFG_DEFINES_SVH
`define CLKGEN_CFG_DEFINES_SVH

// Address byte that selects this receiver, write direction included.
`define CLKGEN_SLAVE_ADDR 8'hd2

// Byte positions inside one write sequence, address byte at index 0.
`define CLKGEN_IDX_ADDR 4'h0
`define CLKGEN_IDX_DATA0 4'h3
`define CLKGEN_IDX_DATA7 4'ha
`define CLKGEN_IDX_PAST 4'hb
`define CLKGEN_BITS_PER_BYTE 4'h8

// Power-up values of data bytes 0 to 7.
`define CLKGEN_DEF_BYTE0 8'h00
`define CLKGEN_DEF_BYTE1 8'hcf
`define CLKGEN_DEF_BYTE2 8'h7f
`define CLKGEN_DEF_BYTE3 8'hff
`define CLKGEN_DEF_BYTE4 8'h00
`define CLKGEN_DEF_BYTE5 8'h00
`define CLKGEN_DEF_BYTE6 8'h00
`define CLKGEN_DEF_BYTE7 8'h07

// Field positions in data bytes 0, 1 and 7.
`define CLKGEN_B0_FUNC_LSB 0
`define CLKGEN_B0_FIX0_SEL 2
`define CLKGEN_B0_FIX1_SEL 3
`define CLKGEN_B0_SEL3 4
`define CLKGEN_B0_SEL4 5
`define CLKGEN_B1_FIX1_EN 7
`define CLKGEN_B1_FIX0_EN 6
`define CLKGEN_B7_PIN_SEL 3'h7

// Function select codes in data byte 0, bits 1 to 0.
`define CLKGEN_FUNC_NORMAL 2'h0
`define CLKGEN_FUNC_TEST 2'h1
`define CLKGEN_FUNC_SPREAD 2'h2
`define CLKGEN_FUNC_HIZ 2'h3

// Frequency ramp: one code step per dwell time.
`define CLKGEN_MCLK_PERIOD_NS 10
`define CLKGEN_RAMP_STEP_NS 10000
`define CLKGEN_RAMP_CYCLES \
  (`CLKGEN_RAMP_STEP_NS / `CLKGEN_MCLK_PERIOD_NS)

`endif

// >>> common/clkgen_cfg_pkg.sv
`default_nettype none
package clkgen_cfg_pkg;

  // Receiver sequencing states.
  typedef enum logic [1:0] {
    st_idle,
    st_bits,
    st_ack,
    st_ignore
  } rx_state_type;

endpackage
`default_nettype wire

// >>> logic/clock_gen_serial_config_write.sv
`timescale 1ns/100ps
`default_nettype none
`include "clkgen_cfg_defines.svh"

module clock_gen_serial_config_write
  import clkgen_cfg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe,
  input  wire logic        base_freq_select_pin,
  output logic [1:0]       fixed_out_en,
  output logic [3:0]       cpu_out_en,
  output logic [6:0]       pci_out_en,
  output logic [7:0]       sdram_out_en,
  output logic [1:0]       fixed_48m_sel,
  output logic             spread_en,
  output logic             pll_bypass,
  output logic             outputs_hiz,
  output logic [2:0]       cpu_freq_code,
  output logic [31:0]      cfg_upper
);

  // Dwell length in system clock cycles and the last value of the 12-bit dwell counter.
  localparam int RAMP_CYCLES = `CLKGEN_RAMP_CYCLES;
  localparam logic [11:0] RAMP_LAST = 12'(RAMP_CYCLES - 1);

  // Power-up value of one data byte slot.
  function automatic logic [7:0] default_byte(input int slot);
    logic [7:0] val;
    val = `CLKGEN_DEF_BYTE0;
    unique case (slot)
      1: val = `CLKGEN_DEF_BYTE1;
      2: val = `CLKGEN_DEF_BYTE2;
      3: val = `CLKGEN_DEF_BYTE3;
      4: val = `CLKGEN_DEF_BYTE4;
      5: val = `CLKGEN_DEF_BYTE5;
      6: val = `CLKGEN_DEF_BYTE6;
      7: val = `CLKGEN_DEF_BYTE7;
      default: val = `CLKGEN_DEF_BYTE0;
    endcase
    return val;
  endfunction

  // True when a sequence position carries one of the data bytes.
  function automatic logic is_data_pos(input logic [3:0] idx);
    return (idx >= `CLKGEN_IDX_DATA0) && (idx <= `CLKGEN_IDX_DATA7);
  endfunction

  // Link side: the shift register runs on the serial clock itself.
  // Data is stable around each rising edge, so no synchroniser is needed.
  logic [7:0] link_shift_q;

  // Each rising serial clock edge shifts in one bit, top bit first.
  always_ff @(posedge serial_clock_pin) begin
    link_shift_q <= {link_shift_q[6:0], serial_data_pin_i};
  end

  // Pin synchronisers in the system clock domain.
  logic scl_s1_q;
  logic scl_s2_q;
  logic scl_s3_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_s3_q;
  logic base_s1_q;
  logic base_s2_q;

  // Two flops per pin; the third only serves edge detection.
  always_ff @(posedge mclk) begin
    scl_s1_q  <= serial_clock_pin;
    scl_s2_q  <= scl_s1_q;
    scl_s3_q  <= scl_s2_q;
    sda_s1_q  <= serial_data_pin_i;
    sda_s2_q  <= sda_s1_q;
    sda_s3_q  <= sda_s2_q;
    base_s1_q <= base_freq_select_pin;
    base_s2_q <= base_s1_q;
  end

  // Bus events seen after synchronisation.
  wire scl_rise   = scl_s2_q & ~scl_s3_q;
  wire scl_fall   = ~scl_s2_q & scl_s3_q;
  wire start_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire stop_cond  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // Receiver state.
  rx_state_type state_q;
  rx_state_type state_d;
  logic [3:0]   bit_cnt_q;
  logic [3:0]   bit_cnt_d;
  logic [3:0]   byte_idx_q;
  logic [3:0]   byte_idx_d;
  logic         ack_oe_q;
  logic         ack_oe_d;

  // The shifted word is read only on the falling edge after its
  // eighth bit, a full half period after the link flop last moved.
  wire byte_done = (state_q == st_bits) && scl_fall &&
                   (bit_cnt_q == `CLKGEN_BITS_PER_BYTE);
  wire addr_match = (link_shift_q == `CLKGEN_SLAVE_ADDR);
  wire addr_byte  = (byte_idx_q == `CLKGEN_IDX_ADDR);

  // A data byte is stored only after a matching address was taken,
  // which holds because a mismatch parks the receiver in st_ignore.
  wire       cfg_wr   = byte_done && is_data_pos(byte_idx_q);
  wire [2:0] cfg_slot = 3'(byte_idx_q - `CLKGEN_IDX_DATA0);

  // Next-state decode of the receiver.
  always_comb begin
    state_d    = state_q;
    bit_cnt_d  = bit_cnt_q;
    byte_idx_d = byte_idx_q;
    ack_oe_d   = ack_oe_q;
    if (start_cond) begin
      // A start always reopens the sequence at the address byte.
      state_d    = st_bits;
      bit_cnt_d  = 4'h0;
      byte_idx_d = `CLKGEN_IDX_ADDR;
      ack_oe_d   = 1'b0;
    end else if (stop_cond) begin
      state_d  = st_idle;
      ack_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        st_idle: begin
          ack_oe_d = 1'b0;
        end
        st_bits: begin
          if (scl_rise && bit_cnt_q != `CLKGEN_BITS_PER_BYTE) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          if (byte_done) begin
            if (addr_byte && !addr_match) begin
              state_d = st_ignore;
            end else begin
              state_d  = st_ack;
              ack_oe_d = 1'b1;
            end
          end
        end
        st_ack: begin
          // Release the data line on the fall that ends the ack bit.
          if (scl_fall) begin
            state_d   = st_bits;
            ack_oe_d  = 1'b0;
            bit_cnt_d = 4'h0;
            if (byte_idx_q != `CLKGEN_IDX_PAST) begin
              byte_idx_d = byte_idx_q + 4'h1;
            end
          end
        end
        st_ignore: begin
          ack_oe_d = 1'b0;
        end
      endcase
    end
  end

  // Receiver registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q    <= st_idle;
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= `CLKGEN_IDX_ADDR;
      ack_oe_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      bit_cnt_q  <= bit_cnt_d;
      byte_idx_q <= byte_idx_d;
      ack_oe_q   <= ack_oe_d;
    end
  end

  // The pin is only ever pulled low for an acknowledge.
  assign serial_data_pin_o  = 1'b0;
  assign serial_data_pin_oe = ack_oe_q;

  // Configuration bytes 0 to 7.
  logic [7:0] cfg_q [0:7];

  // Reset loads defaults; a completed data byte replaces its slot.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        cfg_q[i] <= default_byte(i);
      end
    end else if (cfg_wr) begin
      cfg_q[cfg_slot] <= link_shift_q;
    end
  end

  // Output enables: a cleared bit holds that clock low.
  assign fixed_out_en = {cfg_q[1][`CLKGEN_B1_FIX1_EN],
                         cfg_q[1][`CLKGEN_B1_FIX0_EN]};
  assign cpu_out_en   = cfg_q[1][3:0];
  assign pci_out_en   = cfg_q[2][6:0];
  assign sdram_out_en = cfg_q[3];
  assign cfg_upper    = {cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4]};

  // A set bit picks 48 MHz, a clear one 24 MHz.
  assign fixed_48m_sel = {cfg_q[0][`CLKGEN_B0_FIX1_SEL],
                          cfg_q[0][`CLKGEN_B0_FIX0_SEL]};

  // Function select in byte 0.
  wire [1:0] func_sel = cfg_q[0][`CLKGEN_B0_FUNC_LSB +: 2];
  assign spread_en   = (func_sel == `CLKGEN_FUNC_SPREAD);
  assign pll_bypass  = (func_sel == `CLKGEN_FUNC_TEST);
  assign outputs_hiz = (func_sel == `CLKGEN_FUNC_HIZ);

  // Target frequency code; the base select pin takes part only while
  // byte 7 bits 2 to 0 are all set.
  wire       pin_sel_on  = (cfg_q[7][2:0] == `CLKGEN_B7_PIN_SEL);
  wire       base_bit    = pin_sel_on ? base_s2_q : cfg_q[7][0];
  wire [2:0] freq_target = {cfg_q[0][`CLKGEN_B0_SEL4],
                            cfg_q[0][`CLKGEN_B0_SEL3], base_bit};

  // Frequency ramp state.
  logic [2:0]  freq_code_q;
  logic [11:0] ramp_cnt_q;
  logic        init_done_q;
  wire         ramp_busy = (freq_code_q != freq_target);
  wire         ramp_tick = ramp_busy && (ramp_cnt_q == RAMP_LAST);

  // After reset the code jumps once to the strapped target, then any
  // later change walks one step per dwell so the PLL never sees a jump.
  always_ff @(posedge mclk) begin
    if (rst) begin
      freq_code_q <= 3'h0;
      ramp_cnt_q  <= 12'h000;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      freq_code_q <= freq_target;
      init_done_q <= 1'b1;
    end else if (!ramp_busy) begin
      ramp_cnt_q <= 12'h000;
    end else if (ramp_tick) begin
      ramp_cnt_q  <= 12'h000;
      freq_code_q <= (freq_target > freq_code_q) ?
                     freq_code_q + 3'h1 :
                     freq_code_q - 3'h1;
    end else begin
      ramp_cnt_q <= ramp_cnt_q + 12'h001;
    end
  end

  assign cpu_freq_code = freq_code_q;

endmodule
`default_nettype wire

// >>> test/serial_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// Chipset model: drives the serial clock and data, releases data to 1.
module serial_master_model (
  output logic      scl,
  output logic      sda,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // One bit: data moves 20 ns after the fall, sampled mid high phase.
  task automatic bit_x(input logic b, output logic s);
    #20 sda = b;
    #60 scl = 1'b1;
    #40 s = sda_line;
    #40 scl = 1'b0;
  endtask
  // Start, twelve bytes in fixed order, stop; link clock idles high.
  task automatic xfer(input logic [95:0] d, output logic [11:0] ack);
    logic s;
    sda = 1'b0;
    #80 scl = 1'b0;
    for (int i = 95; i >= 0; i--) begin
      bit_x(d[i], s);
      if (i % 8 == 0) begin
        bit_x(1'b1, s);
        ack[i/8] = !s;
      end
    end
    #20 sda = 1'b0;
    #60 scl = 1'b1;
    #80 sda = 1'b1;
    #160;
  endtask
endmodule
`default_nettype wire

// >>> test/cfg_write_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the acknowledge, stored controls and frequency ramp.
module cfg_write_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        serial_clock_pin,
  input wire logic        serial_data_pin_o,
  input wire logic        serial_data_pin_oe,
  input wire logic [1:0]  fixed_out_en,
  input wire logic [7:0]  sdram_out_en,
  input wire logic        spread_en,
  input wire logic        pll_bypass,
  input wire logic        outputs_hiz,
  input wire logic [2:0]  cpu_freq_code,
  input wire logic [31:0] cfg_upper
);
  logic [10:0] gap_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Counts cycles since the frequency code last moved.
  always_ff @(posedge mclk) begin
    if (rst || $changed(cpu_freq_code)) gap_q <= 11'h000;
    else if (gap_q != 11'h7ff) gap_q <= gap_q + 11'h001;
  end
  a_pull_low_only: assert property (
    serial_data_pin_oe |-> !serial_data_pin_o)
    else $error("data line driven high");
  a_ack_in_low: assert property (
    $rose(serial_data_pin_oe) |-> !serial_clock_pin)
    else $error("ack began with clock high");
  a_ack_hold: assert property (
    $rose(serial_data_pin_oe) |-> serial_data_pin_oe[*8])
    else $error("ack too short");
  a_ack_ends: assert property (
    $rose(serial_data_pin_oe) |-> ##[1:40] !serial_data_pin_oe)
    else $error("ack stuck");
  a_func_onehot: assert property (
    $onehot0({spread_en, pll_bypass, outputs_hiz}))
    else $error("function decode overlap");
  a_store_acked: assert property (
    !$past(rst) && $changed(sdram_out_en) |-> ##[0:2] serial_data_pin_oe)
    else $error("store without ack");
  a_store_clk_low: assert property (
    !$past(rst) && $changed(cfg_upper) |-> !serial_clock_pin)
    else $error("store with clock high");
  a_ramp_step: assert property (
    !$past(rst) && !$past(rst, 2) && $changed(cpu_freq_code) |->
    cpu_freq_code - $past(cpu_freq_code) inside {3'h1, 3'h7})
    else $error("frequency jumped");
  a_ramp_dwell: assert property (
    !$past(rst) && !$past(rst, 2) && $changed(cpu_freq_code) |->
    $past(gap_q) >= 11'h3e6)
    else $error("frequency stepped early");
  // Checked on the first cycle after release, where reset no longer masks it.
  a_reset_vals: assert property (
    $fell(rst) |-> fixed_out_en == 2'h3 && sdram_out_en == 8'hff &&
    cfg_upper == 32'h07000000 && !serial_data_pin_oe)
    else $error("wrong reset value");
endmodule
bind clock_gen_serial_config_write cfg_write_monitor mon (.mclk, .rst,
  .serial_clock_pin, .serial_data_pin_o, .serial_data_pin_oe, .fixed_out_en,
  .sdram_out_en, .spread_en, .pll_bypass, .outputs_hiz, .cpu_freq_code,
  .cfg_upper);
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk = 1'b0, rst = 1'b1, base = 1'b0;
  logic scl, msda, so, soe, spr, byp, hiz;
  logic [1:0] fen, fsel;
  logic [3:0] cen;
  logic [6:0] pen;
  logic [7:0] sen;
  logic [2:0] code;
  logic [31:0] up;
  logic [11:0] ack;
  int err_count = 0, checks_done = 0, cyc = 0;
  wire logic [22:0] en_v = {fen, cen, pen, sen, fsel};
  // Open-drain line: low when either party pulls it low.
  wire logic sda = msda & !(soe && !so);
  serial_master_model m (.scl(scl), .sda(msda), .sda_line(sda));
  clock_gen_serial_config_write uut (.mclk(mclk), .rst(rst),
    .serial_clock_pin(scl), .serial_data_pin_i(sda), .serial_data_pin_o(so),
    .serial_data_pin_oe(soe), .base_freq_select_pin(base), .fixed_out_en(fen),
    .cpu_out_en(cen), .pci_out_en(pen), .sdram_out_en(sen),
    .fixed_48m_sel(fsel), .spread_en(spr), .pll_bypass(byp),
    .outputs_hiz(hiz), .cpu_freq_code(code), .cfg_upper(up));
  always #5 mclk = !mclk;
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  task chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Reserved bits are sent as zero; command and count carry junk.
  task wr(input logic [7:0] a, input logic [7:0] b0);
    m.xfer({a, 8'hff, 8'ha5, b0, 8'h45, 8'h2a, 8'h96, 8'h11, 8'h22,
            8'h33, 8'h44, 8'hee}, ack);
  endtask
  task t_reset;
    chk(en_v, {2'h3, 4'hf, 7'h7f, 8'hff, 2'h0});
    chk({up, spr, byp, hiz, code}, {32'h07000000, 6'h00});
    $display("test reset done");
  endtask
  task t_bad;
    wr(8'hd3, 8'h03);
    chk(ack, 12'h000);
    chk({en_v, up, hiz}, {23'h7ffffc, 32'h07000000, 1'b0});
    $display("test bad address done");
  endtask
  task t_good;
    wr(8'hd2, 8'h24);
    chk(ack, 12'hfff);
    chk(en_v, {2'h1, 4'h5, 7'h2a, 8'h96, 2'h1});
    chk(up, 32'h44332211);
    $display("test write done");
  endtask
  task t_ramp;
    chk(code, 3'h1);
    repeat (3000) @(posedge mclk);
    #3;
    chk(code, 3'h4);
    $display("test ramp done");
  endtask
  task t_func;
    for (int c = 0; c < 4; c++) begin
      wr(8'hd2, 8'h24 | 8'(c));
      chk({spr, byp, hiz}, {c == 2, c == 1, c == 3});
    end
    $display("test function codes done");
  endtask
  // A reset in mid-run restores every default; the strap pin sets the code.
  task t_rerst;
    @(posedge mclk);
    rst  <= 1'b1;
    base <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #3;
    chk(en_v, {2'h3, 4'hf, 7'h7f, 8'hff, 2'h0});
    chk({up, spr, byp, hiz, code}, {32'h07000000, 6'h01});
    $display("test second reset done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #3;
    t_reset();
    t_bad();
    t_good();
    t_ramp();
    t_func();
    t_rerst();
    stop_test();
  end
endmodule
`default_nettype wire
